// ==== src/prc_pkg.sv ====
// Constants and types for the PCI read prefetch control block
package prc_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CLEAR  = 5'h08;
  localparam logic [4:0] OFF_ENABLE = 5'h0c;
  localparam logic [4:0] OFF_STATE  = 5'h10;

  // Control field positions
  localparam int MRM_LSB = 4;
  localparam int MRL_LSB = 6;
  localparam int MR_LSB  = 8;
  localparam int TOL_BIT = 10;
  localparam int CHK_BIT = 11;
  localparam int CTRL_W  = 12;

  // Read multiple policy resets to 10, the others to 00
  localparam logic [11:0] CTRL_RESET = 12'h020;

  // Status bit positions
  localparam int EV_CMD_CHANGE = 0;
  localparam int EV_RESERVED   = 1;
  localparam int EV_MALFORMED  = 2;
  localparam int EV_W          = 3;
  localparam logic [2:0] EV_RESET = 3'h0;

  // Policy field codes
  localparam logic [1:0] POL_00 = 2'h0;
  localparam logic [1:0] POL_01 = 2'h1;
  localparam logic [1:0] POL_10 = 2'h2;
  localparam logic [1:0] POL_11 = 2'h3;

  typedef enum logic [1:0] {
    CMD_MR,
    CMD_MRL,
    CMD_MRM,
    CMD_OTHER
  } prc_cmd_e;

  typedef enum logic [1:0] {
    LEN_SINGLE,
    LEN_LINE,
    LEN_FULL,
    LEN_DWORD
  } prc_len_e;

endpackage : prc_pkg

// ==== src/prc_if.sv ====
// Carrier between the control top and the delayed read decoder
`timescale 1ns/100ps
interface prc_if;
  logic                  req_valid;
  prc_pkg::prc_cmd_e     req_cmd;
  logic [31:0]           req_addr;
  logic [3:0]            req_be;
  logic                  req_pref;
  logic                  data_ready;
  logic [1:0]            cfg_mr;
  logic [1:0]            cfg_mrl;
  logic [1:0]            cfg_mrm;
  logic                  cfg_tol;
  logic                  cfg_chk;
  logic                  res_retry;
  logic                  res_complete;
  logic                  res_abort;
  prc_pkg::prc_len_e     res_len;
  logic                  res_cmd_change;
  logic                  res_reserved;
  logic                  pend_valid;

  modport ctl (output req_valid, req_cmd, req_addr, req_be, req_pref, data_ready,
               cfg_mr, cfg_mrl, cfg_mrm, cfg_tol, cfg_chk,
               input res_retry, res_complete, res_abort, res_len, res_cmd_change,
               res_reserved, pend_valid);
  modport dec (input req_valid, req_cmd, req_addr, req_be, req_pref, data_ready,
               cfg_mr, cfg_mrl, cfg_mrm, cfg_tol, cfg_chk,
               output res_retry, res_complete, res_abort, res_len, res_cmd_change,
               res_reserved, pend_valid);
endinterface : prc_if

// ==== src/prc_dec.sv ====
// Delayed read tracker and prefetch length decoder
`timescale 1ns/100ps
module prc_dec (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Request and answer
  prc_if.dec        pi
);

  typedef struct packed {
    logic              pend_valid;
    prc_pkg::prc_cmd_e pend_cmd;
    logic [31:0]       pend_addr;
    logic [3:0]        pend_be;
  } prc_dec_s;

  prc_dec_s st;
  prc_dec_s next_st;
  logic     match;
  logic     same_cmd;
  logic     bad;

  always_comb begin
    next_st           = st;
    pi.res_retry      = 1'b0;
    pi.res_complete   = 1'b0;
    pi.res_abort      = 1'b0;
    pi.res_cmd_change = 1'b0;
    pi.res_reserved   = 1'b0;
    pi.res_len        = prc_pkg::LEN_SINGLE;
    match    = st.pend_valid && (st.pend_addr == pi.req_addr) && (st.pend_be == pi.req_be);
    same_cmd = st.pend_cmd == pi.req_cmd;
    // Extra checks: empty byte enables or unaligned address
    bad = pi.cfg_chk && ((pi.req_be == 4'h0) || (pi.req_addr[1:0] != 2'h0)); // [R9]
    if (pi.req_pref) begin
      case (pi.req_cmd)
        prc_pkg::CMD_MR: begin
          case (pi.cfg_mr) // [R6]
            prc_pkg::POL_00: pi.res_len = prc_pkg::LEN_LINE;
            prc_pkg::POL_10: pi.res_len = prc_pkg::LEN_FULL;
            prc_pkg::POL_11: pi.res_len = prc_pkg::LEN_DWORD;
            default: begin
              pi.res_len      = prc_pkg::LEN_LINE;
              pi.res_reserved = pi.req_valid;
            end
          endcase
        end
        prc_pkg::CMD_MRL: begin
          pi.res_len = (pi.cfg_mrl == prc_pkg::POL_00) ? prc_pkg::LEN_LINE // [R2]
                                                       : prc_pkg::LEN_FULL; // [R3] [R4] [R5]
        end
        prc_pkg::CMD_MRM: begin
          pi.res_len = (pi.cfg_mrm == prc_pkg::POL_00) ? prc_pkg::LEN_LINE
                                                       : prc_pkg::LEN_FULL; // [R1]
        end
        default: pi.res_len = prc_pkg::LEN_SINGLE;
      endcase
    end else if (pi.req_cmd == prc_pkg::CMD_MR && pi.cfg_mr == prc_pkg::POL_11) begin
      pi.res_len = prc_pkg::LEN_DWORD;
    end
    if (pi.req_valid) begin
      if (bad) begin
        pi.res_abort = 1'b1;
      end else if (!st.pend_valid) begin
        // Queue a new delayed read and retry the master
        next_st.pend_valid = 1'b1;
        next_st.pend_cmd   = pi.req_cmd;
        next_st.pend_addr  = pi.req_addr;
        next_st.pend_be    = pi.req_be;
        pi.res_retry       = 1'b1;
      end else if (match && !same_cmd && !pi.cfg_tol) begin
        pi.res_retry      = 1'b1; // [R7]
        pi.res_cmd_change = 1'b1;
      end else if (match && pi.data_ready) begin
        pi.res_complete    = 1'b1; // [R8]
        next_st.pend_valid = 1'b0;
      end else begin
        pi.res_retry = 1'b1;
      end
    end
  end

  assign pi.pend_valid = st.pend_valid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : prc_dec

// ==== src/prc_top.sv ====
// PCI read prefetch control: registers, interrupt and answer stage
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
// What this block does
// R1 - Read multiple policy resets to full prefetch; 11 also keeps leftover on any end.
// R2 - Read line policy 00 prefetches exactly one cache line when prefetchable.
// R3 - Read line policy 01 prefetches fully, keeps leftover after master disconnect.
// R4 - Read line policy 10 prefetches fully and keeps no leftover.
// R5 - Read line policy 11 prefetches fully, keeps leftover whoever ends the read.
// R6 - Memory read policy: 00 one line, 01 reserved, 10 full, 11 one dword.
// R7 - Tolerance clear: retry a repeated read whose command code changed.
// R8 - Tolerance set: changed read command completes if address and enables match and data_ready is high.
// R9 - Bit 11 enables the extra malformed request checks.
module prc_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Read request from the PCI target logic
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_cmd,
  input  wire logic [31:0] req_addr,
  input  wire logic [3:0]  req_be,
  input  wire logic        req_pref,
  input  wire logic        data_ready,
  // Burst end and discard timer
  input  wire logic        burst_end,
  input  wire logic        end_by_master,
  input  wire logic        discard_expired,
  // Answer
  output logic             rsp_valid,
  output logic             rsp_retry,
  output logic             rsp_complete,
  output logic             rsp_abort,
  output logic      [1:0]  rsp_len,
  output logic             hold_leftover,
  output logic             malformed_chk_en,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    logic [11:0]       ctrl;
    logic [2:0]        status;
    logic [2:0]        enable;
    logic [31:0]       rdata;
    logic              waitreq;
    logic              rsp_valid;
    logic              rsp_retry;
    logic              rsp_complete;
    logic              rsp_abort;
    logic [1:0]        rsp_len;
    prc_pkg::prc_cmd_e last_cmd;
    logic              last_pref;
    logic              hold;
    logic              irq;
  } prc_top_s;

  prc_top_s    st;
  prc_top_s    next_st;
  logic [2:0]  ev;
  logic [31:0] rd_mux;
  logic [1:0]  pol;
  logic        keep;
  logic        acc;

  prc_if pi ();

  assign pi.req_valid  = req_valid;
  assign pi.req_cmd    = prc_pkg::prc_cmd_e'(req_cmd);
  assign pi.req_addr   = req_addr;
  assign pi.req_be     = req_be;
  assign pi.req_pref   = req_pref;
  assign pi.data_ready = data_ready;
  assign pi.cfg_mrm    = st.ctrl[prc_pkg::MRM_LSB +: 2];
  assign pi.cfg_mrl    = st.ctrl[prc_pkg::MRL_LSB +: 2];
  assign pi.cfg_mr     = st.ctrl[prc_pkg::MR_LSB +: 2];
  assign pi.cfg_tol    = st.ctrl[prc_pkg::TOL_BIT];
  assign pi.cfg_chk    = st.ctrl[prc_pkg::CHK_BIT];

  prc_dec u_dec (
    .core_clk (core_clk),
    .rst      (rst),
    .pi       (pi.dec)
  );

  always_comb begin
    next_st = st;
    ev      = 3'h0;
    ev[prc_pkg::EV_CMD_CHANGE] = pi.res_cmd_change;
    ev[prc_pkg::EV_RESERVED]   = pi.res_reserved;
    ev[prc_pkg::EV_MALFORMED]  = pi.res_abort;

    // Register read mux, unmapped reads as zero
    rd_mux = 32'h0;
    case (avs_address)
      prc_pkg::OFF_CTRL:   rd_mux[prc_pkg::CTRL_W-1:0] = st.ctrl;
      prc_pkg::OFF_STATUS: rd_mux[prc_pkg::EV_W-1:0] = st.status;
      prc_pkg::OFF_ENABLE: rd_mux[prc_pkg::EV_W-1:0] = st.enable;
      prc_pkg::OFF_STATE:  rd_mux[1:0] = {st.hold, pi.pend_valid};
      default:             rd_mux = 32'h0;
    endcase

    // One wait cycle, then accept on the edge waitrequest is low
    acc = (avs_read || avs_write) && !st.waitreq;
    if ((avs_read || avs_write) && st.waitreq) begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = rd_mux;
    end else begin
      next_st.waitreq = 1'b1;
    end

    if (acc && avs_write && avs_address == prc_pkg::OFF_CTRL) begin
      if (avs_byteenable[0]) begin
        next_st.ctrl[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        next_st.ctrl[11:8] = avs_writedata[11:8];
      end
    end
    if (acc && avs_write && avs_address == prc_pkg::OFF_ENABLE && avs_byteenable[0]) begin
      next_st.enable = avs_writedata[prc_pkg::EV_W-1:0];
    end
    // Write one to clear; a new event in the same cycle wins
    if (acc && avs_write && avs_address == prc_pkg::OFF_CLEAR && avs_byteenable[0]) begin
      next_st.status = st.status & ~avs_writedata[prc_pkg::EV_W-1:0];
    end
    next_st.status = next_st.status | ev;
    next_st.irq    = |(next_st.status & next_st.enable);

    // Answer stage
    next_st.rsp_valid    = req_valid;
    next_st.rsp_retry    = pi.res_retry;
    next_st.rsp_complete = pi.res_complete;
    next_st.rsp_abort    = pi.res_abort;
    next_st.rsp_len      = pi.res_len;
    if (pi.res_complete) begin
      next_st.last_cmd  = pi.req_cmd;
      next_st.last_pref = pi.req_pref;
      next_st.hold      = 1'b0;
    end

    // Leftover retention on burst end
    pol  = prc_pkg::POL_00;
    keep = 1'b0;
    case (st.last_cmd)
      prc_pkg::CMD_MRL: pol = st.ctrl[prc_pkg::MRL_LSB +: 2];
      prc_pkg::CMD_MRM: pol = st.ctrl[prc_pkg::MRM_LSB +: 2];
      default:          pol = prc_pkg::POL_00;
    endcase
    if (st.last_cmd == prc_pkg::CMD_MRL || st.last_cmd == prc_pkg::CMD_MRM) begin
      case (pol)
        prc_pkg::POL_01: keep = end_by_master; // [R3]
        prc_pkg::POL_11: keep = 1'b1; // [R1] [R5]
        default:         keep = 1'b0; // [R2] [R4]
      endcase
    end
    if (discard_expired) begin
      next_st.hold = 1'b0;
    end
    if (burst_end) begin
      next_st.hold = keep && st.last_pref;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.ctrl     <= prc_pkg::CTRL_RESET;
      st.status   <= prc_pkg::EV_RESET;
      st.enable   <= prc_pkg::EV_RESET;
      st.waitreq  <= 1'b1;
      st.last_cmd <= prc_pkg::CMD_MR;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata     = st.rdata;
  assign avs_waitrequest  = st.waitreq;
  assign rsp_valid        = st.rsp_valid;
  assign rsp_retry        = st.rsp_retry;
  assign rsp_complete     = st.rsp_complete;
  assign rsp_abort        = st.rsp_abort;
  assign rsp_len          = st.rsp_len;
  assign hold_leftover    = st.hold;
  assign malformed_chk_en = st.ctrl[prc_pkg::CHK_BIT]; // [R9]
  assign irq              = st.irq;

endmodule : prc_top

// ==== tb/prc_top_monitor.sv ====
// Concurrent checks on the read prefetch control top ports
`timescale 1ns/100ps
module prc_mon (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  // Request side
  input wire logic        req_valid,
  input wire logic        burst_end,
  input wire logic        discard_expired,
  // Answer side
  input wire logic        rsp_valid,
  input wire logic        rsp_retry,
  input wire logic        rsp_complete,
  input wire logic        rsp_abort,
  input wire logic        hold_leftover,
  input wire logic        malformed_chk_en,
  input wire logic        irq
);
  logic acc, ctl_wr, quiet, chk_q;
  assign acc    = avs_write && !avs_waitrequest;
  assign ctl_wr = acc && avs_address == prc_pkg::OFF_CTRL && avs_byteenable[1];
  // Writes that leave no enabled event behind
  assign quiet  = acc && avs_byteenable[0] && ((avs_address == prc_pkg::OFF_CLEAR &&
                  avs_writedata[2:0] == 3'h7) || (avs_address == prc_pkg::OFF_ENABLE &&
                  avs_writedata[2:0] == 3'h0));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      chk_q <= 1'b0;
    else if (ctl_wr)
      chk_q <= avs_writedata[prc_pkg::CHK_BIT];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_rsp; req_valid |=> rsp_valid && $onehot({rsp_retry, rsp_complete, rsp_abort});
  endproperty
  a_rsp: assert property (p_rsp) else $error("bad answer");
  property p_cause; rsp_valid |-> $past(req_valid); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_chk; ctl_wr |-> ##2 malformed_chk_en == chk_q; endproperty
  a_chk: assert property (p_chk) else $error("check enable wrong");
  property p_abort; rsp_valid && rsp_abort |-> $past(malformed_chk_en); endproperty
  a_abort: assert property (p_abort) else $error("abort with checks off");
  property p_hold_clr; discard_expired && !burst_end |=> !hold_leftover; endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("hold kept past discard");
  property p_hold_set; $rose(hold_leftover) |-> $past(burst_end); endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold without burst end");
  property p_irq; !req_valid ##1 quiet && !req_valid ##1 !req_valid |=> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq stuck");
  c_done: cover property (rsp_valid && rsp_complete);
  c_hold: cover property ($rose(hold_leftover));
  c_irq: cover property ($rose(irq));
endmodule : prc_mon
bind prc_top prc_mon mon_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .req_valid, .burst_end,
  .discard_expired, .rsp_valid, .rsp_retry, .rsp_complete, .rsp_abort, .hold_leftover,
  .malformed_chk_en, .irq);

// ==== tb/prc_master.sv ====
// Model of an external PCI master issuing memory reads
`timescale 1ns/100ps
module prc_master (
  // Clock
  input  wire logic        core_clk,
  // Request lines
  output logic             req_valid = 1'b0,
  output logic      [1:0]  req_cmd = 2'h0,
  output logic      [31:0] req_addr = 32'h0,
  output logic      [3:0]  req_be = 4'h0,
  output logic             req_pref = 1'b0
);
  task automatic issue(input logic [1:0] c, input logic [31:0] a, input logic [3:0] b,
                       input logic p);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_addr  <= a;
    req_be    <= b;
    req_pref  <= p;
    @(posedge core_clk);
    // Released lines show no stale value
    req_valid <= 1'b0;
    req_cmd   <= ~c;
    req_addr  <= ~a;
    req_be    <= ~b;
    req_pref  <= ~p;
  endtask : issue
endmodule : prc_master

// ==== tb/prc_top_tb.sv ====
// Self-checking bench for the read prefetch control block
`timescale 1ns/100ps
module prc_top_tb;
  logic        core_clk, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, data_ready = 1'b0;
  logic        burst_end = 1'b0, end_by_master = 1'b0, discard_expired = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, req_addr;
  logic [3:0]  avs_byteenable = 4'hf, req_be;
  logic [1:0]  req_cmd, rsp_len;
  logic        avs_waitrequest, req_valid, req_pref, rsp_valid, rsp_retry, rsp_complete;
  logic        rsp_abort, hold_leftover, malformed_chk_en, irq;
  int          fails = 0, tests_run = 0;
  prc_master model_u (.core_clk, .req_valid, .req_cmd, .req_addr, .req_be, .req_pref);
  prc_top dut_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .req_valid, .req_cmd, .req_addr,
    .req_be, .req_pref, .data_ready, .burst_end, .end_by_master, .discard_expired,
    .rsp_valid, .rsp_retry, .rsp_complete, .rsp_abort, .rsp_len, .hold_leftover,
    .malformed_chk_en, .irq);
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      give_verdict();
    end
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rd
  task automatic pci(input logic [1:0] c, input logic [31:0] a, input logic [3:0] b,
                     input logic p, input logic [2:0] e);
    model_u.issue(c, a, b, p);
    #1;
    check(rsp_valid, 1'b1);
    check({rsp_retry, rsp_complete, rsp_abort}, e);
  endtask : pci
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  function automatic logic [1:0] pol(input logic [1:0] c, input logic [11:0] r);
    return (c == 2'h0) ? r[9:8] : (c == 2'h1) ? r[7:6] : r[5:4];
  endfunction : pol
  function automatic logic [1:0] exp_len(input logic [1:0] c, input logic p,
                                         input logic [11:0] r);
    if (c == 2'h0 && pol(c, r) == 2'h3) return 2'h3;
    if (!p) return 2'h0;
    return (pol(c, r) == 2'h0 || (c == 2'h0 && pol(c, r) == 2'h1)) ? 2'h1 : 2'h2;
  endfunction : exp_len
  function automatic logic exp_keep(input logic [1:0] c, input logic p,
                                    input logic [11:0] r, input logic m);
    return p && c != 2'h0 && (pol(c, r) == 2'h3 || (pol(c, r) == 2'h1 && m));
  endfunction : exp_keep
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    logic [31:0] a;
    logic [11:0] r;
    logic [3:0]  b;
    logic [1:0]  c;
    logic        pf, bm;
    a = $urandom(32'hf581);
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    check(avs_waitrequest, 1'b1);
    rd(prc_pkg::OFF_CTRL, 32'h20);
    rd(5'h14, 32'h0);
    rd(prc_pkg::OFF_CLEAR, 32'h0);
    for (int i = 0; i < 48; i++) begin
      c  = 2'(i % 3);
      r  = {2'h0, {3{2'(i / 3 % 4)}}, 4'h0};
      pf = 1'(i / 12 % 2);
      a  = $urandom & 32'hffff_fffc;
      b  = 4'($urandom_range(15, 1));
      bm = 1'($urandom);
      wr(prc_pkg::OFF_CTRL, 32'(r));
      data_ready <= 1'b0;
      pci(c, a, b, pf, 3'b100);
      @(posedge core_clk);
      data_ready <= 1'b1;
      pci(c, a, b, pf, 3'b010);
      check(rsp_len, exp_len(c, pf, r));
      @(posedge core_clk);
      data_ready    <= 1'b0;
      burst_end     <= 1'b1;
      end_by_master <= bm;
      @(posedge core_clk);
      burst_end <= 1'b0;
      tick(1);
      check(hold_leftover, exp_keep(c, pf, r, bm));
      rd(prc_pkg::OFF_STATE, {30'h0, exp_keep(c, pf, r, bm), 1'b0});
      @(posedge core_clk);
      discard_expired <= 1'b1;
      @(posedge core_clk);
      discard_expired <= 1'b0;
      #1;
      check(hold_leftover, 1'b0);
    end
    rd(prc_pkg::OFF_STATUS, 32'h2);
    wr(prc_pkg::OFF_CLEAR, 32'h7);
    wr(prc_pkg::OFF_CTRL, 32'h20);
    pci(2'h0, a, 4'hf, 1'b1, 3'b100);
    rd(prc_pkg::OFF_STATE, 32'h1);
    data_ready <= 1'b1;
    pci(2'h1, a, 4'hf, 1'b1, 3'b100);
    rd(prc_pkg::OFF_STATUS, 32'h1);
    pci(2'h0, a, 4'hf, 1'b1, 3'b010);
    check(irq, 1'b0);
    wr(prc_pkg::OFF_ENABLE, 32'h1);
    tick(2);
    check(irq, 1'b1);
    wr(prc_pkg::OFF_CLEAR, 32'h1);
    tick(2);
    check(irq, 1'b0);
    wr(prc_pkg::OFF_CTRL, 32'h420);
    data_ready <= 1'b0;
    pci(2'h0, a + 32'h10, 4'h3, 1'b1, 3'b100);
    @(posedge core_clk);
    data_ready <= 1'b1;
    pci(2'h2, a + 32'h10, 4'h3, 1'b1, 3'b010);
    check(rsp_len, 2'h2);
    @(posedge core_clk);
    data_ready <= 1'b0;
    wr(prc_pkg::OFF_CTRL, 32'h820);
    tick(1);
    check(malformed_chk_en, 1'b1);
    pci(2'h0, a + 32'h20, 4'h0, 1'b1, 3'b001);
    rd(prc_pkg::OFF_STATUS, 32'h4);
    wr(prc_pkg::OFF_CTRL, 32'h20);
    tick(1);
    check(malformed_chk_en, 1'b0);
    pci(2'h0, a + 32'h20, 4'h0, 1'b1, 3'b100);
    // Other command codes get no prefetch
    pci(2'h3, a + 32'h30, 4'hf, 1'b1, 3'b100);
    check(rsp_len, 2'h0);
    give_verdict();
  end
endmodule : prc_top_tb
